// >>> mfc_pkg.sv
/*
  Shared constants and types of the flow controller Modbus register bank.
  Assumes a byte-level UART outside that frames characters and flags the
  inter-frame silence; this package holds no logic.
*/
package mfc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (Modbus holding-register numbers) and gas name length in words
  // ----------------------------------------------------------------------
  localparam logic [15:0] OFF_LINK_CHECK = 16'h0001;
  localparam logic [15:0] OFF_FLOW_FLOAT = 16'h0010;
  localparam logic [15:0] OFF_FLOW_PCT   = 16'h0016;
  localparam logic [15:0] OFF_SP_FLOAT   = 16'h0020;
  localparam logic [15:0] OFF_SP_PCT     = 16'h0026;
  localparam logic [15:0] OFF_VALVE_MODE = 16'h002a;
  localparam logic [15:0] OFF_IF_SELECT  = 16'h002d;
  localparam logic [15:0] OFF_SLAVE_ADDR = 16'h0030;
  localparam logic [15:0] OFF_BIT_RATE   = 16'h0031;
  localparam logic [15:0] OFF_PARITY     = 16'h0032;
  localparam logic [15:0] OFF_AUTO_ZERO  = 16'h0041;
  localparam logic [15:0] OFF_VOL_TOTAL  = 16'h0051;
  localparam logic [15:0] OFF_VOL_CLEAR  = 16'h0053;
  localparam logic [15:0] OFF_WARNING    = 16'h0061;
  localparam logic [15:0] OFF_GAS_NAME   = 16'h0080;
  localparam logic [15:0] OFF_FULL_SCALE = 16'h0087;
  localparam logic [15:0] GAS_WORDS      = 16'h0005;

  // ----------------------------------------------------------------------
  // Values, keys and reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] LINK_CHECK_VAL = 16'h0101;
  localparam logic [15:0] RST_SLAVE_ADDR = 16'h0001;
  localparam logic [15:0] SLAVE_ADDR_MAX = 16'h0063;
  localparam logic [15:0] RST_BIT_RATE   = 16'h0060;
  localparam logic [22:0] RATE_MULT      = 23'h000064;
  localparam logic [15:0] RST_VALVE_MODE = 16'h0000;
  localparam logic [15:0] VALVE_OPEN     = 16'h0002;
  localparam logic [15:0] RST_IF_SELECT  = 16'h0001;
  localparam logic [15:0] RST_SP_PCT     = 16'h0000;
  localparam logic [31:0] RST_SP_FLOAT   = 32'h0000_0000;
  localparam logic [15:0] PCT_FULL       = 16'h2710;
  localparam logic [15:0] AUTO_ZERO_KEY  = 16'h00f0;
  localparam logic [15:0] VOL_CLEAR_KEY  = 16'h0001;

  // ----------------------------------------------------------------------
  // Framing
  // ----------------------------------------------------------------------
  localparam logic [7:0]  FC_READ      = 8'h03;
  localparam logic [7:0]  FC_WRITE     = 8'h10;
  localparam logic [15:0] MAX_REGS     = 16'h0008;
  localparam int          BUF_DEPTH    = 32;
  localparam logic [5:0]  BUF_LIMIT    = 6'h20;
  localparam logic [5:0]  RD_FRAME_LEN = 6'h08;
  localparam logic [5:0]  WR_HDR_LEN   = 6'h09;
  localparam logic [15:0] CRC_INIT     = 16'hffff;
  localparam logic [15:0] CRC_POLY     = 16'ha001;

  typedef enum logic [1:0] {
    MFC_PAR_NONE = 2'h0,
    MFC_PAR_ODD  = 2'h1,
    MFC_PAR_EVEN = 2'h2
  } mfc_parity_t;

  typedef enum logic [1:0] {
    MFC_IDLE   = 2'h0,
    MFC_WRITE  = 2'h1,
    MFC_TX     = 2'h3,
    MFC_COMMIT = 2'h2
  } mfc_state_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } mfc_byte_t;

  typedef struct packed {
    logic [6:0]  address;
    logic [22:0] bit_rate;
    mfc_parity_t parity;
  } mfc_link_cfg_t;

endpackage

// >>> mfc_modbus_regs.sv
/*
  Modbus-RTU slave register bank of a mass flow controller: frame check,
  function 03 reads, function 10 writes, one-shot commands, totaliser.
  Assumes a UART outside that delivers received bytes one cycle each,
  pulses rx_frame_end on the inter-frame silence, applies link_cfg to its
  bit timing, and takes tx_byte with a valid/ready handshake.
*/
`timescale 1ns/10ps

module mfc_modbus_regs
  import mfc_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire mfc_byte_t     rx_byte,
  input  wire logic          rx_frame_end,
  output mfc_byte_t          tx_byte,
  input  wire logic          tx_ready,
  output logic               tx_drive_en,
  output mfc_link_cfg_t      link_cfg,
  input  wire logic [31:0]   flow_float,
  input  wire logic [15:0]   flow_percent,
  input  wire logic [15:0]   warning_in,
  input  wire logic [79:0]   gas_name,
  input  wire logic [31:0]   full_scale,
  input  wire logic          vol_inc_valid,
  input  wire logic [15:0]   vol_inc,
  output logic [31:0]        setpoint_float,
  output logic [15:0]        setpoint_percent,
  output logic               setpoint_use_percent,
  output logic [15:0]        valve_mode,
  output logic               valve_full_open,
  output logic [15:0]        if_select,
  output logic               auto_zero_start
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [7:0]  rx_buf [BUF_DEPTH];
  logic [5:0]  rx_cnt;
  logic [15:0] rx_crc, tx_crc, pend_addr, pend_rate, pend_parity;
  mfc_state_t  st;
  logic [4:0]  idx;
  logic [2:0]  wi;
  logic [31:0] volume_total;
  logic [7:0]  fc, gen_byte;
  logic [15:0] reg_start, reg_count, wr_addr, wr_data;
  logic [15:0] rd_addr, rd_word, gas_idx;
  logic [2:0]  cnt_m1;
  logic        rx_ovf, count_ok, rd_ok, wr_ok, frame_ok, is_read, wr_en;
  logic [4:0]  tx_len, wr_idx, k;

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------------
  // Bytes arriving while a request is processed or answered are dropped:
  // the line is half duplex, so they can only be noise or a collision.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rx_cnt <= 6'h00;
      rx_crc <= CRC_INIT;
      rx_ovf <= 1'b0;
    end else if (st != MFC_IDLE || rx_frame_end) begin
      rx_cnt <= 6'h00;
      rx_crc <= CRC_INIT;
      rx_ovf <= 1'b0;
    end else if (rx_byte.valid) begin
      if (rx_cnt < BUF_LIMIT) begin
        rx_cnt <= rx_cnt + 6'h01;
        rx_crc <= crc_step(rx_crc, rx_byte.data);
      end else begin
        rx_ovf <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (st == MFC_IDLE && rx_byte.valid && rx_cnt < BUF_LIMIT) begin
      rx_buf[rx_cnt[4:0]] <= rx_byte.data;
    end
  end

  // ----------------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------------
  assign fc        = rx_buf[1];
  assign reg_start = {rx_buf[2], rx_buf[3]};
  assign reg_count = {rx_buf[4], rx_buf[5]};
  assign cnt_m1    = 3'(reg_count - 16'h0001);
  assign count_ok  = reg_count != 16'h0000 && reg_count <= MAX_REGS;
  assign rd_ok     = fc == FC_READ && rx_cnt == RD_FRAME_LEN;
  // Byte count must agree with the register count and the frame length
  assign wr_ok     = fc == FC_WRITE &&
                     rx_buf[6] == {reg_count[6:0], 1'b0} &&
                     rx_cnt == WR_HDR_LEN + {reg_count[4:0], 1'b0};
  // The remainder of a good CRC run over its own CRC bytes is zero
  assign frame_ok  = !rx_ovf && rx_crc == 16'h0000 &&
                     {8'h00, rx_buf[0]} == {9'h000, link_cfg.address} &&
                     count_ok && (rd_ok || wr_ok);
  assign is_read   = fc == FC_READ;
  assign tx_len    = is_read ? 5'(5'h03 + {reg_count[3:0], 1'b0})
                             : 5'h06;

  // ----------------------------------------------------------------------
  // Frame sequencer and transmit byte stream
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st      <= MFC_IDLE;
      idx     <= 5'h00;
      wi      <= 3'h0;
      tx_crc  <= CRC_INIT;
      tx_byte <= '0;
    end else begin
      unique case (st)
        MFC_IDLE: begin
          idx    <= 5'h00;
          wi     <= 3'h0;
          tx_crc <= CRC_INIT;
          if (rx_frame_end && frame_ok) begin
            st <= is_read ? MFC_TX : MFC_WRITE;
          end
        end
        MFC_WRITE: begin
          wi <= wi + 3'h1;
          if (wi == cnt_m1) begin
            st <= MFC_TX;
          end
        end
        MFC_TX: begin
          if (!tx_byte.valid || tx_ready) begin
            if (idx < tx_len) begin
              tx_byte <= '{valid: 1'b1, data: gen_byte};
              tx_crc  <= crc_step(tx_crc, gen_byte);
              idx     <= idx + 5'h01;
            end else if (idx == tx_len) begin
              tx_byte <= '{valid: 1'b1, data: tx_crc[7:0]};
              idx     <= idx + 5'h01;
            end else if (idx == 5'(tx_len + 5'h01)) begin
              tx_byte <= '{valid: 1'b1, data: tx_crc[15:8]};
              idx     <= idx + 5'h01;
            end else begin
              tx_byte.valid <= 1'b0;
              st            <= MFC_COMMIT;
            end
          end
        end
        MFC_COMMIT: begin
          st <= MFC_IDLE;
        end
      endcase
    end
  end

  assign tx_drive_en = st == MFC_TX;

  // ----------------------------------------------------------------------
  // Reply byte generator
  // ----------------------------------------------------------------------
  assign k       = 5'(idx - 5'h03);
  assign rd_addr = reg_start + {12'h000, k[4:1]};
  assign gas_idx = rd_addr - OFF_GAS_NAME;

  // Data of a read is sent high byte first in each register
  always_comb begin
    gen_byte = 8'h00;
    if (idx == 5'h00) begin
      gen_byte = rx_buf[0];
    end else if (idx == 5'h01) begin
      gen_byte = fc;
    end else if (is_read && idx == 5'h02) begin
      gen_byte = {reg_count[6:0], 1'b0};
    end else if (is_read) begin
      gen_byte = k[0] ? rd_word[7:0] : rd_word[15:8];
    end else begin
      gen_byte = rx_buf[idx];
    end
  end

  // Float and U32 quantities put the low-order word at the lower number;
  // write-only and unmapped registers read as zero.
  always_comb begin
    rd_word = 16'h0000;
    unique case (rd_addr)
      OFF_LINK_CHECK:         rd_word = LINK_CHECK_VAL;
      OFF_FLOW_FLOAT:         rd_word = flow_float[15:0];
      OFF_FLOW_FLOAT + 16'h1: rd_word = flow_float[31:16];
      OFF_FLOW_PCT:           rd_word = flow_percent;
      OFF_SP_FLOAT:           rd_word = setpoint_float[15:0];
      OFF_SP_FLOAT + 16'h1:   rd_word = setpoint_float[31:16];
      OFF_SP_PCT:             rd_word = setpoint_percent;
      OFF_VALVE_MODE:         rd_word = valve_mode;
      OFF_IF_SELECT:          rd_word = if_select;
      OFF_SLAVE_ADDR:         rd_word = pend_addr;
      OFF_BIT_RATE:           rd_word = pend_rate;
      OFF_PARITY:             rd_word = pend_parity;
      OFF_VOL_TOTAL:          rd_word = volume_total[15:0];
      OFF_VOL_TOTAL + 16'h1:  rd_word = volume_total[31:16];
      OFF_WARNING:            rd_word = warning_in;
      OFF_FULL_SCALE:         rd_word = full_scale[15:0];
      OFF_FULL_SCALE + 16'h1: rd_word = full_scale[31:16];
      default: begin
        // First register holds the first two characters
        if (gas_idx < GAS_WORDS) begin
          rd_word = gas_name[7'(16'h0040 - {gas_idx[11:0], 4'h0}) +: 16];
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  assign wr_en   = st == MFC_WRITE;
  assign wr_addr = reg_start + {13'h0000, wi};
  assign wr_idx  = 5'(5'h07 + {1'b0, wi, 1'b0});
  assign wr_data = {rx_buf[wr_idx], rx_buf[5'(wr_idx + 5'h01)]};

  // Out-of-range link values are ignored so the device stays reachable
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pend_addr   <= RST_SLAVE_ADDR;
      pend_rate   <= RST_BIT_RATE;
      pend_parity <= {14'h0000, MFC_PAR_NONE};
    end else if (wr_en) begin
      if (wr_addr == OFF_SLAVE_ADDR && wr_data != 16'h0000 &&
          wr_data <= SLAVE_ADDR_MAX) begin
        pend_addr <= wr_data;
      end
      if (wr_addr == OFF_BIT_RATE && wr_data != 16'h0000) begin
        pend_rate <= wr_data;
      end
      if (wr_addr == OFF_PARITY && wr_data <= 16'h0002) begin
        pend_parity <= wr_data;
      end
    end
  end

  // New link settings wait until the reply has left in the old format
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      link_cfg <= '{address:  RST_SLAVE_ADDR[6:0],
                    bit_rate: 23'(RST_BIT_RATE) * RATE_MULT,
                    parity:   MFC_PAR_NONE};
    end else if (st == MFC_COMMIT) begin
      link_cfg.address  <= pend_addr[6:0];
      link_cfg.bit_rate <= 23'(pend_rate) * RATE_MULT;
      link_cfg.parity   <= mfc_parity_t'(pend_parity[1:0]);
    end
  end

  // Both setpoints stay readable; the last one written is the active one
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      setpoint_float       <= RST_SP_FLOAT;
      setpoint_percent     <= RST_SP_PCT;
      setpoint_use_percent <= 1'b0;
    end else if (wr_en) begin
      if (wr_addr == OFF_SP_FLOAT) begin
        setpoint_float[15:0] <= wr_data;
        setpoint_use_percent <= 1'b0;
      end
      if (wr_addr == OFF_SP_FLOAT + 16'h1) begin
        setpoint_float[31:16] <= wr_data;
        setpoint_use_percent  <= 1'b0;
      end
      if (wr_addr == OFF_SP_PCT) begin
        setpoint_percent <= (wr_data > PCT_FULL) ? PCT_FULL : wr_data;
        setpoint_use_percent <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      valve_mode      <= RST_VALVE_MODE;
      valve_full_open <= 1'b0;
      if_select       <= RST_IF_SELECT;
    end else if (wr_en) begin
      if (wr_addr == OFF_VALVE_MODE) begin
        valve_mode      <= wr_data;
        valve_full_open <= wr_data == VALVE_OPEN;
      end
      if (wr_addr == OFF_IF_SELECT) begin
        if_select <= wr_data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      auto_zero_start <= 1'b0;
    end else begin
      auto_zero_start <= wr_en && wr_addr == OFF_AUTO_ZERO &&
                         wr_data == AUTO_ZERO_KEY;
    end
  end

  // An increment that lands with a clear is kept, not lost
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      volume_total <= 32'h0000_0000;
    end else if (wr_en && wr_addr == OFF_VOL_CLEAR &&
                 wr_data == VOL_CLEAR_KEY) begin
      volume_total <= vol_inc_valid ? {16'h0000, vol_inc} : 32'h0;
    end else if (vol_inc_valid) begin
      volume_total <= volume_total + {16'h0000, vol_inc};
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_reset_link_cfg: assert property (@(posedge clk)
    $rose(reset_n) |-> link_cfg.bit_rate == 23'h002580 &&
      link_cfg.parity == MFC_PAR_NONE && link_cfg.address == 7'h01)
    else $error("link format after reset is not the factory one");
  chk_bad_frame_ignored: assert property (@(posedge clk)
    disable iff (!reset_n)
    (st == MFC_IDLE && rx_frame_end && !frame_ok) |=> st == MFC_IDLE)
    else $error("frame with wrong address or CRC was acted on");
  chk_cfg_after_ack: assert property (@(posedge clk)
    disable iff (!reset_n)
    $changed(link_cfg) |-> $past(st) == MFC_COMMIT && !tx_byte.valid)
    else $error("link settings changed before reply was sent");
  chk_rate_times_100: assert property (@(posedge clk)
    disable iff (!reset_n)
    $past(st) == MFC_COMMIT |->
      link_cfg.bit_rate == 23'($past(pend_rate)) * 23'h000064)
    else $error("bit rate is not the register value times 100");
  chk_auto_zero_pulse: assert property (@(posedge clk)
    disable iff (!reset_n)
    auto_zero_start |-> $past(wr_en) && $past(wr_data) == 16'h00f0
      ##1 !auto_zero_start)
    else $error("auto-zero pulse without key write or too long");
  chk_total_clear: assert property (@(posedge clk)
    disable iff (!reset_n)
    (wr_en && wr_addr == OFF_VOL_CLEAR && wr_data == 16'h0001 &&
     !vol_inc_valid) |=> volume_total == 32'h0)
    else $error("volume total not cleared by clear command");
  chk_valve_open: assert property (@(posedge clk)
    disable iff (!reset_n)
    (wr_en && wr_addr == OFF_VALVE_MODE) |=>
      valve_full_open == (valve_mode == 16'h0002))
    else $error("valve open output disagrees with mode");
  chk_read_byte_count: assert property (@(posedge clk)
    disable iff (!reset_n)
    (st == MFC_TX && is_read && idx == 5'h02 &&
     (!tx_byte.valid || tx_ready)) |=>
      tx_byte.data == {$past(reg_count[6:0]), 1'b0})
    else $error("read reply byte count is not twice the count");
  chk_tx_hold: assert property (@(posedge clk)
    disable iff (!reset_n)
    (tx_byte.valid && !tx_ready) |=> tx_byte.valid && $stable(tx_byte.data))
    else $error("transmit byte dropped while not accepted");
  chk_link_check: assert property (@(posedge clk)
    disable iff (!reset_n)
    (st == MFC_TX && is_read && idx >= 5'h03 && idx < tx_len &&
     rd_addr == OFF_LINK_CHECK && (!tx_byte.valid || tx_ready)) |=>
      tx_byte.data == 8'h01)
    else $error("link check register did not return 0x0101");

endmodule

// >>> mfc_host_model.sv
/*
  Modbus-RTU host model for the flow controller register bank: frames
  requests with CRC and collects the reply through the tx handshake.
  Assumes the bank's byte-level link ports and one shared clock.
*/
`timescale 1ns/10ps
module mfc_host_model
  import mfc_pkg::*;
(
  input  wire logic      clk,
  output mfc_byte_t      rx_byte,
  output logic           rx_frame_end,
  input  wire mfc_byte_t tx_byte,
  output logic           tx_ready,
  input  wire logic      tx_drive_en
);
  logic slow = 1'b0;

  initial begin
    rx_byte = '0;
    rx_frame_end = 1'b0;
    tx_ready = 1'b1;
  end

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return c;
  endfunction

  // ----------------------------------------------------------------
  // Request: bytes, CRC low then high, then the silence marker
  // ----------------------------------------------------------------
  task automatic send(input logic [7:0] f[$], input logic bad);
    logic [15:0] c;
    c = crc16(f) ^ {15'h0000, bad};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    foreach (f[i]) begin
      @(posedge clk);
      #1 rx_byte = {1'b1, f[i]};
    end
    @(posedge clk);
    // Idle data flips so a stale byte never looks like a fresh one
    #1 rx_byte = {1'b0, ~rx_byte.data};
    rx_frame_end = 1'b1;
    @(posedge clk);
    #1 rx_frame_end = 1'b0;
  endtask

  // Slow mode stalls every other cycle
  task automatic recv(output logic [7:0] r[$]);
    r = {};
    for (int n = 0; n < 200; n++) begin
      @(posedge clk);
      if (tx_byte.valid && tx_ready) r.push_back(tx_byte.data);
      if (r.size() > 0 && !tx_drive_en) break;
      #1 tx_ready = slow ? ~tx_ready : 1'b1;
    end
    #1 tx_ready = 1'b1;
  endtask
endmodule

// >>> tb_flow_controller_modbus_regs.sv
/*
  Self-checking bench of the flow controller register bank.
  Assumes mfc_pkg and the host model; one 40 MHz clock.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  err_count++; $display("BAD %0t got %0h exp %0h", $time, (a), (b)); end end

module tb_flow_controller_modbus_regs
  import mfc_pkg::*;
();
  logic          clk = 1'b0;
  logic          reset_n = 1'b0;
  mfc_byte_t     rx_byte;
  mfc_byte_t     tx_byte;
  mfc_link_cfg_t link_cfg;
  logic          rx_frame_end;
  logic          tx_ready;
  logic          tx_drive_en;
  logic [31:0]   flow_float = 32'h447a_0000;
  logic [15:0]   flow_percent = 16'h2710;
  logic [15:0]   warning_in = 16'h0123;
  logic [79:0]   gas_name = 80'h4e49_5452_4f47_454e_2020;
  logic [31:0]   full_scale = 32'h4496_0000;
  logic          vol_inc_valid = 1'b0;
  logic [15:0]   vol_inc = 16'h0000;
  logic [31:0]   setpoint_float;
  logic [15:0]   setpoint_percent;
  logic          setpoint_use_percent;
  logic [15:0]   valve_mode;
  logic          valve_full_open;
  logic [15:0]   if_select;
  logic          auto_zero_start;
  logic [7:0]    dev = 8'h01;
  logic [7:0]    got[$];
  logic [7:0]    want[$];
  int            err_count = 0;
  int            samples_checked = 0;
  int            az_seen = 0;

  always #12.5 clk = ~clk;

  always @(posedge clk) begin
    if (auto_zero_start === 1'b1) az_seen <= az_seen + 1;
  end

  mfc_modbus_regs mfc_modbus_regs_i (
    .clk, .reset_n, .rx_byte, .rx_frame_end, .tx_byte, .tx_ready,
    .tx_drive_en, .link_cfg, .flow_float, .flow_percent, .warning_in,
    .gas_name, .full_scale, .vol_inc_valid, .vol_inc, .setpoint_float,
    .setpoint_percent, .setpoint_use_percent, .valve_mode,
    .valve_full_open, .if_select, .auto_zero_start
  );

  mfc_host_model host_i (
    .clk, .rx_byte, .rx_frame_end, .tx_byte, .tx_ready, .tx_drive_en
  );

  // ----------------------------------------------------------------
  // Transfer tasks
  // ----------------------------------------------------------------
  task automatic expect_reply;
    logic [15:0] k;
    k = host_i.crc16(want);
    want.push_back(k[7:0]);
    want.push_back(k[15:8]);
    host_i.recv(got);
    `CHK(tx_drive_en, 1'b0)
    `CHK(got.size(), want.size())
    foreach (want[i]) if (i < got.size()) `CHK(got[i], want[i])
    @(posedge clk);
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] w[$]);
    logic [7:0] c[$];
    c = {dev, FC_READ, a[15:8], a[7:0], 8'h00, 8'(w.size())};
    host_i.send(c, 1'b0);
    `CHK(tx_drive_en, 1'b1)
    want = {dev, FC_READ, 8'(2 * w.size())};
    foreach (w[i]) want = {want, w[i][15:8], w[i][7:0]};
    expect_reply();
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] w[$]);
    logic [7:0]    c[$];
    mfc_link_cfg_t old;
    old = link_cfg;
    c = {dev, FC_WRITE, a[15:8], a[7:0], 8'h00, 8'(w.size())};
    c = {c, 8'(2 * w.size())};
    foreach (w[i]) c = {c, w[i][15:8], w[i][7:0]};
    host_i.send(c, 1'b0);
    `CHK(link_cfg, old)
    want = c[0:5];
    expect_reply();
    repeat (2) @(posedge clk);
  endtask

  task automatic quiet(input logic [7:0] c[$], input logic bad);
    host_i.send(c, bad);
    host_i.recv(got);
    `CHK(got.size(), 0)
  endtask

  task automatic bump(input logic [15:0] v);
    @(posedge clk);
    #1 vol_inc_valid = 1'b1;
    vol_inc = v;
    @(posedge clk);
    #1 vol_inc_valid = 1'b0;
  endtask

  task automatic wrap_up;
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    `CHK(link_cfg, mfc_link_cfg_t'{7'h01, 23'h002580, MFC_PAR_NONE})
    `CHK(link_cfg.address, 7'h01)
    `CHK(valve_mode, 16'h0000)
    `CHK(if_select, 16'h0001)
    rd(OFF_LINK_CHECK, '{16'h0101});
    rd(OFF_FLOW_FLOAT, '{16'h0000, 16'h447a});
    host_i.slow = 1'b1;
    rd(OFF_FLOW_PCT, '{16'h2710});
    rd(OFF_WARNING, '{16'h0123});
    rd(OFF_GAS_NAME, '{16'h4e49, 16'h5452, 16'h4f47, 16'h454e,
                       16'h2020});
    rd(OFF_FULL_SCALE, '{16'h0000, 16'h4496});
    rd(OFF_AUTO_ZERO, '{16'h0000, 16'h0000});
    host_i.slow = 1'b0;
    wr(OFF_SP_FLOAT, '{16'h0000, 16'h447a});
    `CHK(setpoint_float, 32'h447a_0000)
    `CHK(setpoint_use_percent, 1'b0)
    rd(OFF_SP_FLOAT, '{16'h0000, 16'h447a});
    wr(OFF_SP_PCT, '{16'h2710});
    `CHK(setpoint_percent, PCT_FULL)
    `CHK(setpoint_use_percent, 1'b1)
    wr(OFF_VALVE_MODE, '{16'h0002});
    `CHK(valve_full_open, 1'b1)
    `CHK(valve_mode, 16'h0002)
    wr(OFF_VALVE_MODE, '{16'h0000});
    `CHK(valve_full_open, 1'b0)
    wr(OFF_AUTO_ZERO, '{16'h00ef});
    `CHK(az_seen, 0)
    wr(OFF_AUTO_ZERO, '{16'h00f0});
    `CHK(az_seen, 1)
    bump(16'h8000);
    bump(16'h9000);
    rd(OFF_VOL_TOTAL, '{16'h1000, 16'h0001});
    wr(OFF_VOL_CLEAR, '{16'h0002});
    rd(OFF_VOL_TOTAL, '{16'h1000, 16'h0001});
    wr(OFF_VOL_CLEAR, '{16'h0001});
    rd(OFF_VOL_TOTAL, '{16'h0000, 16'h0000});
    quiet('{8'h02, FC_READ, 8'h00, 8'h01, 8'h00, 8'h01}, 1'b0);
    quiet('{dev, FC_READ, 8'h00, 8'h01, 8'h00, 8'h01}, 1'b1);
    wr(OFF_BIT_RATE, '{16'h0030});
    `CHK(link_cfg.bit_rate, 23'h0012c0)
    for (int p = 0; p < 3; p++) begin
      wr(OFF_PARITY, '{16'(p)});
      `CHK(link_cfg.parity, p[1:0])
    end
    wr(OFF_SLAVE_ADDR, '{16'h0005});
    `CHK(link_cfg.address, 7'h05)
    dev = 8'h05;
    rd(OFF_LINK_CHECK, '{16'h0101});
    quiet('{8'h01, FC_READ, 8'h00, 8'h01, 8'h00, 8'h01}, 1'b0);
    wrap_up();
  end

  initial begin
    #(20000 * 25);
    err_count++;
    wrap_up();
  end
endmodule
